// File: hw/sppm_idle_timer.sv
`include "sppm_regs.svh"
`default_nettype none
// =====================================
// Idle timer: counts cycles of idle transmitter with nothing pending.
module sppm_idle_timer #(
  parameter int IDLE_CYC = `SPPM_IDLE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic idle,
  output logic expired
);
  logic [15:0] cnt_r; // Idle cycles seen so far.
  logic [15:0] cnt_nxt; // Next count.
  logic expired_nxt; // Next expired flag.
  // Count up while idle, restart on any activity.
  always_comb begin
    cnt_nxt = cnt_r;
    expired_nxt = 1'b0;
    if (!idle) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_r < 16'(IDLE_CYC)) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    expired_nxt = idle && (cnt_nxt >= 16'(IDLE_CYC));
  end
  // Register the count.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 16'h0000;
      expired <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expired <= expired_nxt;
    end
  end
endmodule // sppm_idle_timer
`default_nettype wire

// File: hw/sppm_top.sv
// Notes on behaviour
// - Store slot limit message scale and value.
// - Compare captured limit after reset release.
// - Both below minimum: apply selected action.
// - Three-bit override field selects action.
// - Stop only masked secondary clocks.
// - Unsupported-request mode, config and limit exempt.
// - Low D-state starts L1 or L2/L3.
// - Internal bus clock runs only in D0.
// - Active-state low-power entry only when idle long enough.
// - Honour active-state enable field.
// - Report exit latencies in link capabilities.
// - Capability structures at fixed offsets.
`include "sppm_regs.svh"
`default_nettype none
module sppm_top #(
  parameter int IDLE_CYC = `SPPM_IDLE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pcie_rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic spl_msg,
  input wire logic [1:0] spl_scale,
  input wire logic [7:0] spl_value,
  input wire logic tlp_valid,
  input wire logic tlp_is_cfg,
  input wire logic tlp_is_spl,
  output logic tlp_ur,
  input wire logic tx_idle,
  input wire logic tx_pending,
  output logic power_override_pin,
  output logic [7:0] sec_clk_en,
  output logic int_pci_clk_en,
  output logic [1:0] link_state
);
  // =====================================
  // State.
  logic [1:0] cap_scale_r, cap_scale_nxt; // Captured slot power scale.
  logic [7:0] cap_value_r, cap_value_nxt; // Captured slot power value.
  logic [31:0] gen_ctl_r, gen_ctl_nxt; // General control register.
  logic [7:0] clk_mask_r, clk_mask_nxt; // Secondary clock mask, 1 disables.
  logic [1:0] dstate_r, dstate_nxt; // Power state from control/status.
  logic [1:0] aspm_r, aspm_nxt; // Active-state enable field.
  logic prst_d_r, prst_d_nxt; // Delayed PCIe reset level.
  logic act_pin_r, act_pin_nxt; // Pin action latched.
  logic act_clk_r, act_clk_nxt; // Clock action latched.
  logic act_ur_r, act_ur_nxt; // Unsupported-request action latched.
  sppm_pkg::sppm_link_type link_r, link_nxt; // Link power state.
  logic [31:0] rdata_nxt; // Next read data.
  logic tlp_ur_nxt; // Next UR flag.
  logic idle_ok; // Idle timer expired.
  sppm_pkg::sppm_action_type act_sel; // Decoded override field.
  logic [1:0] min_scale; // Minimum scale field.
  logic [7:0] min_value; // Minimum value field.
  assign act_sel = sppm_pkg::sppm_action_type'(gen_ctl_r[`SPPM_GC_ACTION_LSB +: 3]);
  assign min_scale = gen_ctl_r[`SPPM_GC_MIN_SCALE_LSB +: 2];
  assign min_value = gen_ctl_r[`SPPM_GC_MIN_VALUE_LSB +: 8];

  // =====================================
  // Idle timer for active-state entry.
  sppm_idle_timer #(.IDLE_CYC(IDLE_CYC)) u_idle (
    .clk(clk),
    .arst_n(arst_n),
    .idle(tx_idle && !tx_pending),
    .expired(idle_ok)
  );

  // Read multiplexer returning register contents.
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `SPPM_OFF_PM_CAP: v = {16'h0003, `SPPM_OFF_PM_CSR, 8'h01};
      `SPPM_OFF_PM_CSR: v = {30'h0000_0000, dstate_r};
      `SPPM_OFF_PCIE_CAP: v = {16'h0001, 8'h00, 8'h10};
      `SPPM_OFF_DEV_CAP: v = {4'h0, cap_scale_r, cap_value_r, 18'h00000};
      `SPPM_OFF_LINK_CAP: v = {14'h0000, `SPPM_L1_LAT, `SPPM_L0S_LAT, 12'hc00};
      `SPPM_OFF_LINK_CTL: v = {30'h0000_0000, aspm_r};
      `SPPM_OFF_GEN_CTL: v = gen_ctl_r;
      8'hd8: v = {16'h0000, clk_mask_r, 8'h00};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // =====================================
  // Register, capture and override next-state logic.
  always_comb begin
    cap_scale_nxt = cap_scale_r;
    cap_value_nxt = cap_value_r;
    gen_ctl_nxt = gen_ctl_r;
    clk_mask_nxt = clk_mask_r;
    dstate_nxt = dstate_r;
    aspm_nxt = aspm_r;
    prst_d_nxt = pcie_rst_n;
    act_pin_nxt = act_pin_r;
    act_clk_nxt = act_clk_r;
    act_ur_nxt = act_ur_r;
    rdata_nxt = cfg_rd ? rd_mux(cfg_addr) : 32'h0000_0000;
    // Captured grant taken from the limit message.
    if (spl_msg) begin
      cap_scale_nxt = spl_scale;
      cap_value_nxt = spl_value;
    end
    if (cfg_wr) begin
      case (cfg_addr)
        `SPPM_OFF_GEN_CTL: gen_ctl_nxt = cfg_wdata;
        8'hd8: clk_mask_nxt = cfg_wdata[15:8];
        `SPPM_OFF_PM_CSR: dstate_nxt = cfg_wdata[1:0];
        `SPPM_OFF_LINK_CTL: aspm_nxt = cfg_wdata[1:0];
        default: begin
        end
      endcase
    end
    // Actions cleared while the PCIe reset is held.
    if (!pcie_rst_n) begin
      act_pin_nxt = 1'b0;
      act_clk_nxt = 1'b0;
      act_ur_nxt = 1'b0;
    end else if (!prst_d_r) begin
      // First cycle after release: evaluate once.
      if (cap_scale_r < min_scale && cap_value_r < min_value) begin
        act_pin_nxt = (act_sel == sppm_pkg::SPPM_ACT_PIN) || (act_sel == sppm_pkg::SPPM_ACT_CLK_PIN);
        act_clk_nxt = (act_sel == sppm_pkg::SPPM_ACT_CLK) || (act_sel == sppm_pkg::SPPM_ACT_CLK_PIN);
        act_ur_nxt = (act_sel == sppm_pkg::SPPM_ACT_UR);
      end
    end
    tlp_ur_nxt = act_ur_r && tlp_valid && !tlp_is_cfg && !tlp_is_spl;
  end

  // =====================================
  // Link power state machine.
  always_comb begin
    link_nxt = link_r;
    case (link_r)
      sppm_pkg::SPPM_LINK_L0: begin
        if (dstate_r == 2'h3) begin
          link_nxt = sppm_pkg::SPPM_LINK_L23;
        end else if (dstate_r != 2'h0) begin
          link_nxt = sppm_pkg::SPPM_LINK_L1;
        end else if (idle_ok && aspm_r[1]) begin
          link_nxt = sppm_pkg::SPPM_LINK_L1;
        end else if (idle_ok && aspm_r[0]) begin
          link_nxt = sppm_pkg::SPPM_LINK_L0S;
        end
      end
      sppm_pkg::SPPM_LINK_L0S, sppm_pkg::SPPM_LINK_L1: begin
        if (dstate_r == 2'h3) begin
          link_nxt = sppm_pkg::SPPM_LINK_L23;
        end else if (dstate_r != 2'h0) begin
          // A low D-state reached from L0s must still end in L1.
          link_nxt = sppm_pkg::SPPM_LINK_L1;
        end else if (dstate_r == 2'h0 && !idle_ok) begin
          link_nxt = sppm_pkg::SPPM_LINK_L0;
        end
      end
      sppm_pkg::SPPM_LINK_L23: begin
        if (dstate_r == 2'h0) begin
          link_nxt = sppm_pkg::SPPM_LINK_L0;
        end
      end
      default: link_nxt = sppm_pkg::SPPM_LINK_L0;
    endcase
  end

  // =====================================
  // Registers and outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_scale_r <= 2'h0;
      cap_value_r <= 8'h00;
      gen_ctl_r <= `SPPM_GC_RESET;
      clk_mask_r <= `SPPM_CLK_MASK_RESET;
      dstate_r <= 2'h0;
      aspm_r <= 2'h0;
      prst_d_r <= 1'b0;
      act_pin_r <= 1'b0;
      act_clk_r <= 1'b0;
      act_ur_r <= 1'b0;
      link_r <= sppm_pkg::SPPM_LINK_L0;
      cfg_rdata <= 32'h0000_0000;
      tlp_ur <= 1'b0;
      power_override_pin <= 1'b0;
      sec_clk_en <= 8'hff;
      int_pci_clk_en <= 1'b1;
      link_state <= 2'h0;
    end else begin
      cap_scale_r <= cap_scale_nxt;
      cap_value_r <= cap_value_nxt;
      gen_ctl_r <= gen_ctl_nxt;
      clk_mask_r <= clk_mask_nxt;
      dstate_r <= dstate_nxt;
      aspm_r <= aspm_nxt;
      prst_d_r <= prst_d_nxt;
      act_pin_r <= act_pin_nxt;
      act_clk_r <= act_clk_nxt;
      act_ur_r <= act_ur_nxt;
      link_r <= link_nxt;
      cfg_rdata <= rdata_nxt;
      tlp_ur <= tlp_ur_nxt;
      power_override_pin <= act_pin_nxt;
      sec_clk_en <= act_clk_nxt ? ~clk_mask_nxt : 8'hff;
      int_pci_clk_en <= (dstate_nxt == 2'h0);
      link_state <= link_nxt;
    end
  end

  // =====================================
  // Checks.
  a_spl_capture: assert property (@(posedge clk) disable iff (!arst_n)
    spl_msg |=> (cap_scale_r == $past(spl_scale) && cap_value_r == $past(spl_value)))
    else $error("slot limit not captured");
  // The internal clock gate follows the D-state written by the host.
  a_clk_gate_d0: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_wr && cfg_addr == `SPPM_OFF_PM_CSR) |=> (int_pci_clk_en == ($past(cfg_wdata[1:0]) == 2'h0)))
    else $error("internal clock gate wrong");
  a_ur_exempt: assert property (@(posedge clk) disable iff (!arst_n)
    tlp_ur |-> $past(act_ur_r && !tlp_is_cfg && !tlp_is_spl))
    else $error("bad unsupported request");
  a_clk_mask_use: assert property (@(posedge clk) disable iff (!arst_n)
    (sec_clk_en != 8'hff) |-> act_clk_r)
    else $error("clocks stopped without action");
  // A new mask written while the clock action holds takes effect on the next cycle.
  a_clk_mask_write: assert property (@(posedge clk) disable iff (!arst_n)
    (act_clk_r && pcie_rst_n && prst_d_r && cfg_wr && cfg_addr == 8'hd8) |=>
      (sec_clk_en == ~$past(cfg_wdata[15:8])))
    else $error("clock mask not applied");
  a_low_d_link: assert property (@(posedge clk) disable iff (!arst_n)
    (dstate_r == 2'h3) |-> ##[1:2] (link_state == 2'h3))
    else $error("D3 did not reach L2/L3");
  // D1 and D2 both take the link to L1, except from L2/L3, which only D0 leaves.
  a_mid_d_link: assert property (@(posedge clk) disable iff (!arst_n)
    (dstate_r == 2'h1 || dstate_r == 2'h2) |-> ##[1:2] (link_state == 2'h2))
    else $error("D1 or D2 did not reach L1");
  a_aspm_gate: assert property (@(posedge clk) disable iff (!arst_n)
    (link_r == sppm_pkg::SPPM_LINK_L0 && dstate_r == 2'h0 && aspm_r == 2'h0) |=>
      link_r == sppm_pkg::SPPM_LINK_L0)
    else $error("ASPM entry while disabled");
  a_idle_entry: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(link_r) == sppm_pkg::SPPM_LINK_L0 && link_r == sppm_pkg::SPPM_LINK_L0S) |-> $past(idle_ok))
    else $error("L0s without idle");
  a_action_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (pcie_rst_n && prst_d_r && $past(pcie_rst_n)) |=> $stable(act_pin_r))
    else $error("action changed without reset");
  // One qualifying compare after reset release with a pin action selected.
  sequence s_low_grant_pin;
    pcie_rst_n && !prst_d_r && (cap_scale_r < min_scale) && (cap_value_r < min_value) &&
      (act_sel == sppm_pkg::SPPM_ACT_PIN || act_sel == sppm_pkg::SPPM_ACT_CLK_PIN);
  endsequence
  a_pin_from_act: assert property (@(posedge clk) disable iff (!arst_n)
    s_low_grant_pin |=> power_override_pin)
    else $error("override pin not asserted");
endmodule // sppm_top
`default_nettype wire

// File: include/sppm_pkg.sv
`default_nettype none
// =====================================
// Types shared by the slot power block.
package sppm_pkg;
  // Slot power actions in the override field.
  typedef enum logic [2:0] {
    SPPM_ACT_IGNORE = 3'h0,
    SPPM_ACT_PIN = 3'h1,
    SPPM_ACT_CLK = 3'h2,
    SPPM_ACT_CLK_PIN = 3'h3,
    SPPM_ACT_UR = 3'h4
  } sppm_action_type;
  // Link power states.
  typedef enum logic [1:0] {
    SPPM_LINK_L0 = 2'h0,
    SPPM_LINK_L0S = 2'h1,
    SPPM_LINK_L1 = 2'h2,
    SPPM_LINK_L23 = 2'h3
  } sppm_link_type;
endpackage : sppm_pkg
`default_nettype wire

// File: include/sppm_regs.svh
`ifndef SPPM_REGS_SVH
`define SPPM_REGS_SVH
// =====================================
// Configuration offsets.
`define SPPM_OFF_PM_CAP 8'h48
`define SPPM_OFF_PM_CSR 8'h4c
`define SPPM_OFF_PCIE_CAP 8'h70
`define SPPM_OFF_DEV_CAP 8'h74
`define SPPM_OFF_LINK_CAP 8'h7c
`define SPPM_OFF_LINK_CTL 8'h80
`define SPPM_OFF_GEN_CTL 8'hd4
`define SPPM_OFF_CLK_MASK 8'hd9
// =====================================
// Field positions.
`define SPPM_DC_VALUE_LSB 18
`define SPPM_DC_SCALE_LSB 26
`define SPPM_GC_MIN_VALUE_LSB 0
`define SPPM_GC_MIN_SCALE_LSB 8
`define SPPM_GC_ACTION_LSB 10
`define SPPM_LC_L0S_LAT_LSB 12
`define SPPM_LC_L1_LAT_LSB 15
// =====================================
// Reset values and fixed exit latencies.
`define SPPM_GC_RESET 32'h0000_0000
`define SPPM_CLK_MASK_RESET 8'h00
`define SPPM_L0S_LAT 3'h3
`define SPPM_L1_LAT 3'h5
// =====================================
// Timing: least idle time before low-power entry.
`define SPPM_IDLE_NS 1000
`define SPPM_CLK_NS 8
`define SPPM_IDLE_CYC ((`SPPM_IDLE_NS + `SPPM_CLK_NS - 1) / `SPPM_CLK_NS)
`endif

// File: test/sppm_rc_model.sv
`default_nettype none
// ==========
// Upstream root complex: sends slot limit messages and transactions.
module sppm_rc_model (
  input wire logic clk,
  output logic spl_msg,
  output logic [1:0] spl_scale,
  output logic [7:0] spl_value,
  output logic tlp_valid,
  output logic tlp_is_cfg,
  output logic tlp_is_spl
);
  timeunit 1ns;
  timeprecision 1ps;
  // All lines rest low until the first request.
  initial begin
    {spl_msg, spl_scale, spl_value, tlp_valid, tlp_is_cfg, tlp_is_spl} = '0;
  end
  // One-cycle message; the fields then go stale by inversion.
  task automatic send_spl(input logic [1:0] s, input logic [7:0] v);
    @(negedge clk);
    spl_msg = 1'b1;
    spl_scale = s;
    spl_value = v;
    @(negedge clk);
    spl_msg = 1'b0;
    spl_scale = ~s;
    spl_value = ~v;
  endtask
  // One-cycle transaction of the given kind.
  task automatic send_tlp(input logic c, input logic s);
    @(negedge clk);
    tlp_valid = 1'b1;
    tlp_is_cfg = c;
    tlp_is_spl = s;
    @(negedge clk);
    tlp_valid = 1'b0;
    tlp_is_cfg = ~c;
    tlp_is_spl = ~s;
  endtask
endmodule // sppm_rc_model
`default_nettype wire

// File: test/sppm_top_tb_top.sv
`include "sppm_regs.svh"
`default_nettype none
// ==========
// Bench: the driver queues expectations, the monitor compares.
module sppm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, pcie_rst_n, cfg_wr, cfg_rd, tx_idle, tx_pending, probe, rd_d, pr_d;
  logic spl_msg, tlp_valid, tlp_is_cfg, tlp_is_spl, tlp_ur, power_override_pin, int_pci_clk_en;
  logic [1:0] spl_scale, link_state, sc;
  logic [7:0] cfg_addr, spl_value, sec_clk_en, m, sec;
  logic [31:0] cfg_wdata, cfg_rdata, obs, seed;
  logic [63:0] q[$];
  logic [63:0] e;
  logic pin;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  assign obs = {19'h0, tlp_ur, power_override_pin, sec_clk_en, int_pci_clk_en, link_state};
  // The reference clock runs in every state of this bench.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  sppm_top #(.IDLE_CYC(4)) i_dut (.clk(clk), .arst_n(arst_n), .pcie_rst_n(pcie_rst_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .spl_msg(spl_msg),
    .spl_scale(spl_scale), .spl_value(spl_value), .tlp_valid(tlp_valid), .tlp_is_cfg(tlp_is_cfg),
    .tlp_is_spl(tlp_is_spl), .tlp_ur(tlp_ur), .tx_idle(tx_idle), .tx_pending(tx_pending),
    .power_override_pin(power_override_pin), .sec_clk_en(sec_clk_en), .int_pci_clk_en(int_pci_clk_en),
    .link_state(link_state));
  sppm_rc_model i_rc (.clk(clk), .spl_msg(spl_msg), .spl_scale(spl_scale), .spl_value(spl_value),
    .tlp_valid(tlp_valid), .tlp_is_cfg(tlp_is_cfg), .tlp_is_spl(tlp_is_spl));
  // Marks the cycle in which a read answer or a probed status is valid.
  always @(posedge clk) begin
    rd_d <= cfg_rd;
    pr_d <= probe;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  // Takes the oldest note and compares it under its mask.
  always @(negedge clk) begin
    if (rd_d || pr_d) begin
      e = q.pop_front();
      check_count = check_count + 1;
      if (((rd_d ? cfg_rdata : obs) & e[63:32]) !== e[31:0]) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t got %h exp %h", $time, rd_d ? cfg_rdata : obs, e[31:0]);
      end
    end
  end
  // Expected status word.
  function automatic logic [31:0] ob(logic u, logic p, logic [7:0] s, logic c, logic [1:0] l);
    return {19'h0, u, p, s, c, l};
  endfunction
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge clk);
    {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] mk, logic [31:0] x);
    @(negedge clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    q.push_back({mk, x});
    @(negedge clk);
    cfg_rd = 1'b0;
  endtask
  task automatic chk(logic [31:0] x);
    @(negedge clk);
    probe = 1'b1;
    q.push_back({32'hffff_ffff, x});
    @(negedge clk);
    probe = 1'b0;
  endtask
  task automatic prst();
    @(negedge clk);
    pcie_rst_n = 1'b0;
    step(2);
    pcie_rst_n = 1'b1;
    step(3);
  endtask
  task automatic do_reset();
    {arst_n, pcie_rst_n} = 2'b00;
    step(12);
    arst_n = 1'b1;
    step(2);
    pcie_rst_n = 1'b1;
    step(2);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    {arst_n, pcie_rst_n, cfg_wr, cfg_rd, tx_idle, tx_pending, probe, cfg_addr, cfg_wdata} = '0;
    seed = $urandom(32'h3970);
    do_reset();
    rd(`SPPM_OFF_GEN_CTL, '1, `SPPM_GC_RESET);
    rd(8'hd8, 32'hff00, 32'h0);
    rd(`SPPM_OFF_LINK_CAP, 32'h3f000, {14'h0, `SPPM_L1_LAT, `SPPM_L0S_LAT, 12'h0});
    rd(8'hf0, '1, 32'h0);
    rd(`SPPM_OFF_PM_CAP, 32'hff, 32'h01);
    rd(`SPPM_OFF_PCIE_CAP, 32'hff, 32'h10);
    $display("test regs done");
    sc = 2'($urandom_range(2));
    m = 8'($urandom_range(254));
    i_rc.send_spl(sc, m);
    rd(`SPPM_OFF_DEV_CAP, 32'h0ffc_0000, {4'h0, sc, m, 18'h0});
    wr(`SPPM_OFF_GEN_CTL, {19'h0, 3'h1, sc, 8'hff});
    prst();
    chk(ob(0, 0, 8'hff, 1, 0));
    {pin, sec} = {1'b0, 8'hff};
    // Each action, with the old one holding until the next reset.
    // Codes 5 to 7 must act as ignore; the unsupported-request code runs last for the transaction checks.
    for (int i = 1; i < 8; i++) begin
      int a;
      a = (i < 4) ? i : ((i == 7) ? 4 : i + 1);
      wr(`SPPM_OFF_GEN_CTL, {19'h0, 3'(a), 2'h3, 8'hff});
      chk(ob(0, pin, sec, 1, 0));
      m = 8'($urandom);
      wr(8'hd8, {16'h0, m, 8'h0});
      prst();
      pin = (a < 4) && a[0];
      sec = (a == 2 || a == 3) ? ~m : 8'hff;
      chk(ob(0, pin, sec, 1, 0));
    end
    fork i_rc.send_tlp(0, 0); chk(ob(1, 0, 8'hff, 1, 0)); join
    fork i_rc.send_tlp(1, 0); chk(ob(0, 0, 8'hff, 1, 0)); join
    fork i_rc.send_tlp(0, 1); chk(ob(0, 0, 8'hff, 1, 0)); join
    $display("test slot power done");
    do_reset();
    for (int k = 0; k < 5; k++) begin
      tx_idle = 1'b0;
      tx_pending = (k == 4);
      wr(`SPPM_OFF_LINK_CTL, {30'h0, (k == 4) ? 2'h3 : 2'(k)});
      step(3);
      tx_idle = 1'b1;
      chk(ob(0, 0, 8'hff, 1, sppm_pkg::SPPM_LINK_L0));
      step(16);
      chk(ob(0, 0, 8'hff, 1, (k == 1) ? sppm_pkg::SPPM_LINK_L0S : (k == 2 || k == 3) ? sppm_pkg::SPPM_LINK_L1 :
        sppm_pkg::SPPM_LINK_L0));
    end
    $display("test link idle done");
    tx_pending = 1'b0;
    for (int d = 1; d < 4; d++) begin
      do_reset();
      // Enter L0s first so that the D-state write starts from a low-power link state.
      wr(`SPPM_OFF_LINK_CTL, 32'h0000_0001);
      step(8);
      chk(ob(0, 0, 8'hff, 1, sppm_pkg::SPPM_LINK_L0S));
      wr(`SPPM_OFF_PM_CSR, 32'(d));
      step(2);
      chk(ob(0, 0, 8'hff, 0, (d == 3) ? sppm_pkg::SPPM_LINK_L23 : sppm_pkg::SPPM_LINK_L1));
      rd(`SPPM_OFF_PM_CSR, 32'h0000_0003, 32'(d));
    end
    $display("test d-states done");
    step(2);
    end_sim();
  end
endmodule // sppm_top_tb_top
`default_nettype wire
